// *** logic/angle_calc_regs.svh ***
/*
 Register indices, field positions, reset values and fixed figures of the
 electrical angle timer and waveform unit. Assumes byte address = 4 * index.
*/
`ifndef ANGLE_CALC_REGS_SVH
`define ANGLE_CALC_REGS_SVH
// Register indices
`define IDX_CTRL_A    16'h1fc0
`define IDX_CTRL_B    16'h1fc1
`define IDX_PERIOD    16'h1fc2
`define IDX_ANGLE     16'h1fc4
`define IDX_AMP       16'h1fc6
`define IDX_CAPTURE   16'h1fc8
`define IDX_SINE      16'h1fca
`define IDX_IRQ_STAT  16'h1fcc
`define IDX_IRQ_EN    16'h1fcd
`define IDX_IRQ_CLR   16'h1fce
// Control A fields
`define CA_TIMER_EN   0
`define CA_CALC_EN    1
`define CA_XFER_EN    2
`define CA_THREE_PH   3
`define CA_CLK_LO     4
`define CA_CLK_HI     5
`define CA_PH_ORDER   6
`define CA_DOWN       7
// Control B fields
`define CB_IRQ_SEL    0
`define CB_NO_SYNC    1
`define CB_BUSY       2
`define CB_START      3
// Period fields
`define PER_CORR_HI   15
`define PER_CORR_LO   12
`define PER_DIV_HI    11
// Interrupt status bits
`define IRQ_TIMER     0
`define IRQ_CALC      1
`define IRQ_CAPT      2
// Reset values and angle figures
`define CTRL_A_RST    8'h00
`define PERIOD_RST    16'h0010
`define ANGLE_FULL    10'h168
`define ANGLE_120     10'h078
`define ANGLE_240     10'h0f0
`endif

// *** logic/angle_calc_pkg.sv ***
/*
 Types of the electrical angle timer and waveform unit.
 Assumes the register header is included where the constants are needed.
*/
package angle_calc_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_wait_sync,
    st_fetch,
    st_mult,
    st_shape
  } calc_state_t;
endpackage

// *** logic/sine_table_mem.sv ***
/*
 Sine table memory: one write port, one read port with registered data.
 Assumes write and read on the same clock; read data lag the address by one.
*/
`timescale 1ns/1ns
module sine_table_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 512,
  parameter int AW    = 9
) (
  input  wire logic             i_clock,
  input  wire logic             i_clock_en,
  input  wire logic             i_wr,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("sine table depth exceeds address range");
  end

  // Write and registered read
  always_ff @(posedge i_clock) begin
    if (i_clock_en) begin
      if (i_wr) mem_r[i_waddr] <= i_wdata;
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule

// *** logic/electrical_angle_waveform_calc.sv ***
/*
 Electrical angle timer with waveform arithmetic for three-phase PWM.
 Assumes a plain register port, a position pin from outside the clock
 domain, and PWM compare registers that take o_cmp_* on o_cmp_load.
*/
// How it works
// - Writing one to start bit launches a calculation; zero does nothing.
// - Busy status reads one while a calculation is pending or running.
// - Sync bit zero waits for an angle step; one starts at once.
// - Select bit picks timer-step or calculation-end as the o_irq_pulse source.
// - Angle counts up when direction bit is zero, down when one.
// - Order bit gives V, W as U plus or minus 120 and 240.
// - Clock select divides system clock by 8, 16, 32 or 64.
// - Modulation bit chooses two-phase or three-phase duty shaping.
// - Transfer bit enables copying duties into the compare registers.
// - Calculation runs only while calculation enable bit is one.
// - Angle timer runs only while timer enable bit is one.
// - Period upper nibble adds one tick to n of 16 steps.
// - Angle register takes a written start angle, reads the count.
// - Amplitude register scales the sine data in the calculation.
// - Position detection latches the current angle into the capture.
`timescale 1ns/1ns
`include "angle_calc_regs.svh"
module electrical_angle_waveform_calc
  import angle_calc_pkg::*;
#(
  parameter int SINE_DEPTH = 360
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_clock_en,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  input  wire logic        i_position_detect,
  output logic      [11:0] o_cmp_u,
  output logic      [11:0] o_cmp_v,
  output logic      [11:0] o_cmp_w,
  output logic             o_cmp_load,
  output logic             o_irq,
  output logic             o_irq_pulse
);
  initial begin
    if (SINE_DEPTH < 360 || SINE_DEPTH > 512)
      $error("sine table depth must be 360 to 512");
  end

  //////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  ctrl_a_r;
  logic        irq_sel_r;
  logic        no_sync_r;
  logic [15:0] period_r;
  logic [8:0]  angle_r;
  logic [11:0] amp_r;
  logic [8:0]  capture_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_en_r;
  logic [8:0]  sine_ptr_r;
  calc_state_t state_r;
  logic [1:0]  phase_r;
  logic [8:0]  snap_r;
  logic [11:0] duty_r [3];
  logic [5:0]  presc_r;
  logic [11:0] per_cnt_r;
  logic [3:0]  corr_cnt_r;
  logic [1:0]  pos_sync_r;
  logic        pos_old_r;

  // Address decode
  logic sel_a, sel_b, sel_per, sel_ang, sel_amp, sel_cap, sel_sine;
  logic sel_stat, sel_en, sel_clr;
  assign sel_a    = i_addr == 16'(`IDX_CTRL_A << 2);
  assign sel_b    = i_addr == 16'(`IDX_CTRL_B << 2);
  assign sel_per  = i_addr == 16'(`IDX_PERIOD << 2);
  assign sel_ang  = i_addr == 16'(`IDX_ANGLE << 2);
  assign sel_amp  = i_addr == 16'(`IDX_AMP << 2);
  assign sel_cap  = i_addr == 16'(`IDX_CAPTURE << 2);
  assign sel_sine = i_addr == 16'(`IDX_SINE << 2);
  assign sel_stat = i_addr == 16'(`IDX_IRQ_STAT << 2);
  assign sel_en   = i_addr == 16'(`IDX_IRQ_EN << 2);
  assign sel_clr  = i_addr == 16'(`IDX_IRQ_CLR << 2);

  logic timer_en, calc_en, xfer_en, three_ph, ph_order, down;
  logic [1:0] clk_sel;
  assign timer_en = ctrl_a_r[`CA_TIMER_EN];
  assign calc_en  = ctrl_a_r[`CA_CALC_EN];
  assign xfer_en  = ctrl_a_r[`CA_XFER_EN];
  assign three_ph = ctrl_a_r[`CA_THREE_PH];
  assign ph_order = ctrl_a_r[`CA_PH_ORDER];
  assign down     = ctrl_a_r[`CA_DOWN];
  assign clk_sel  = ctrl_a_r[`CA_CLK_HI:`CA_CLK_LO];

  logic busy;
  assign busy = state_r != st_idle;

  //////////////////////////////////////////////////////////////////////////
  // Software-written registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_a_r  <= `CTRL_A_RST;
      irq_sel_r <= 1'b0;
      no_sync_r <= 1'b0;
      period_r  <= `PERIOD_RST;
      amp_r     <= 12'h000;
      irq_en_r  <= 3'h0;
    end else if (i_clock_en && i_wr) begin
      if (sel_a) ctrl_a_r <= i_wdata[7:0];
      if (sel_b) begin
        irq_sel_r <= i_wdata[`CB_IRQ_SEL];
        no_sync_r <= i_wdata[`CB_NO_SYNC];
      end
      if (sel_per) period_r <= i_wdata;
      if (sel_amp) amp_r <= i_wdata[11:0];
      if (sel_en) irq_en_r <= i_wdata[2:0];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 16'h0000;
    end else if (i_clock_en) begin
      o_rdata <= 16'h0000;
      if (i_rd) begin
        unique case (1'b1)
          sel_a:   o_rdata <= {8'h00, ctrl_a_r};
          sel_b:   o_rdata <= {12'h000, 1'b0, busy, no_sync_r,
                               irq_sel_r};
          sel_per: o_rdata <= period_r;
          sel_ang: o_rdata <= {7'h00, angle_r};
          sel_amp: o_rdata <= {4'h0, amp_r};
          sel_cap: o_rdata <= {7'h00, capture_r};
          sel_stat: o_rdata <= {13'h0000, irq_stat_r};
          sel_en:  o_rdata <= {13'h0000, irq_en_r};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler and period counter
  logic [5:0]  presc_mask;
  logic        tick;
  logic        corr_extra;
  logic        step_ev;
  assign presc_mask = {clk_sel == 2'h3, clk_sel[1], |clk_sel, 3'h7};
  assign tick = timer_en && ((presc_r & presc_mask) == presc_mask);
  assign corr_extra = corr_cnt_r <
                      period_r[`PER_CORR_HI:`PER_CORR_LO];
  assign step_ev = tick && ({1'b0, per_cnt_r} + 13'h0001 >=
                   {1'b0, period_r[`PER_DIV_HI:0]} +
                   {12'h000, corr_extra});

  // Divider chain, frozen while the timer is off
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      presc_r    <= 6'h00;
      per_cnt_r  <= 12'h000;
      corr_cnt_r <= 4'h0;
    end else if (i_clock_en && timer_en) begin
      presc_r <= tick ? 6'h00 : presc_r + 6'h01;
      if (step_ev) begin
        per_cnt_r  <= 12'h000;
        corr_cnt_r <= corr_cnt_r + 4'h1;
      end else if (tick) begin
        per_cnt_r <= per_cnt_r + 12'h001;
      end
    end
  end

  // Electrical angle, write wins over a step
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      angle_r <= 9'h000;
    end else if (i_clock_en) begin
      if (i_wr && sel_ang) begin
        angle_r <= i_wdata[8:0];
      end else if (step_ev) begin
        if (!down)
          angle_r <= ({1'b0, angle_r} + 10'h001 >= `ANGLE_FULL) ?
                     9'h000 : angle_r + 9'h001;
        else
          angle_r <= (angle_r == 9'h000) ?
                     9'(`ANGLE_FULL - 10'h001) : angle_r - 9'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Position capture
  logic cap_ev;
  assign cap_ev = pos_sync_r[1] && !pos_old_r;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pos_sync_r <= 2'h0;
      pos_old_r  <= 1'b0;
      capture_r  <= 9'h000;
    end else if (i_clock_en) begin
      pos_sync_r <= {pos_sync_r[0], i_position_detect};
      pos_old_r  <= pos_sync_r[1];
      if (cap_ev) capture_r <= angle_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sine table fill pointer
  logic sine_wr;
  assign sine_wr = i_wr && sel_sine;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sine_ptr_r <= 9'h000;
    end else if (i_clock_en && sine_wr) begin
      sine_ptr_r <= (sine_ptr_r == 9'(SINE_DEPTH - 1)) ?
                    9'h000 : sine_ptr_r + 9'h001;
    end
  end

  // Phase angle for the phase being fetched
  logic [9:0] offset;
  logic [9:0] ang_sum;
  logic [8:0] rd_angle;
  logic signed [7:0] sine_data;
  always_comb begin
    offset = (phase_r == 2'h1) ? `ANGLE_120 :
             (phase_r == 2'h2) ? `ANGLE_240 : 10'h000;
    ang_sum = ph_order ? {1'b0, snap_r} + (`ANGLE_FULL - offset)
                       : {1'b0, snap_r} + offset;
    if (ang_sum >= `ANGLE_FULL) ang_sum = ang_sum - `ANGLE_FULL;
    rd_angle = ang_sum[8:0];
  end

  sine_table_mem #(
    .WIDTH (8),
    .DEPTH (512),
    .AW    (9)
  ) u_sine (
    .i_clock    (i_clock),
    .i_clock_en (i_clock_en),
    .i_wr       (sine_wr),
    .i_waddr    (sine_ptr_r),
    .i_wdata    (i_wdata[7:0]),
    .i_raddr    (rd_angle),
    .o_rdata    (sine_data)
  );

  // Amplitude scaling: duty = (amp + amp * sine / 128) / 2
  logic signed [20:0] prod;
  logic signed [13:0] sum;
  assign prod = $signed({1'b0, amp_r}) * sine_data;
  assign sum  = 14'(prod >>> 7) + $signed({2'b00, amp_r});

  // Modulation shaping per phase
  logic [11:0] duty_min;
  logic [11:0] shaped [3];
  assign duty_min = (duty_r[0] < duty_r[1]) ?
                    ((duty_r[0] < duty_r[2]) ? duty_r[0] : duty_r[2]) :
                    ((duty_r[1] < duty_r[2]) ? duty_r[1] : duty_r[2]);
  for (genvar k = 0; k < 3; k++) begin : g_shape
    assign shaped[k] = three_ph ? duty_r[k]
                                : duty_r[k] - duty_min;
  end

  //////////////////////////////////////////////////////////////////////////
  // Calculation sequencer
  logic start_req;
  logic calc_done;
  assign start_req = i_wr && sel_b && i_wdata[`CB_START] && calc_en;
  assign calc_done = state_r == st_shape;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= st_idle;
      phase_r <= 2'h0;
      snap_r  <= 9'h000;
      for (int i = 0; i < 3; i++) duty_r[i] <= 12'h000;
    end else if (i_clock_en) begin
      if (!calc_en) begin
        state_r <= st_idle;
      end else begin
        unique case (state_r)
          st_idle: begin
            snap_r  <= angle_r;
            phase_r <= 2'h0;
            // Sync choice written with the start applies to this start
            if (start_req)
              state_r <= i_wdata[`CB_NO_SYNC] ? st_fetch
                                              : st_wait_sync;
          end
          st_wait_sync: begin
            snap_r <= angle_r;
            if (step_ev) state_r <= st_fetch;
          end
          st_fetch: state_r <= st_mult;
          st_mult: begin
            duty_r[phase_r] <= sum[12:1];
            phase_r <= phase_r + 2'h1;
            state_r <= (phase_r == 2'h2) ? st_shape : st_fetch;
          end
          st_shape: state_r <= st_idle;
        endcase
      end
    end
  end

  // Compare transfer
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cmp_u    <= 12'h000;
      o_cmp_v    <= 12'h000;
      o_cmp_w    <= 12'h000;
      o_cmp_load <= 1'b0;
    end else if (i_clock_en) begin
      o_cmp_load <= calc_done && xfer_en;
      if (calc_done && xfer_en) begin
        o_cmp_u <= shaped[0];
        o_cmp_v <= shaped[1];
        o_cmp_w <= shaped[2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, set wins over clear
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set = {cap_ev, calc_done, step_ev};
  assign irq_clr = (i_wr && sel_clr) ? i_wdata[2:0] : 3'h0;
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_stat_r  <= 3'h0;
      o_irq       <= 1'b0;
      o_irq_pulse <= 1'b0;
    end else if (i_clock_en) begin
      irq_stat_r  <= (irq_stat_r & ~irq_clr) | irq_set;
      o_irq       <= |(irq_stat_r & irq_en_r);
      o_irq_pulse <= irq_sel_r ? calc_done : step_ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n || !i_clock_en);

  sequence s_calc_run;
    state_r == st_fetch ##1 state_r == st_mult;
  endsequence

  // Eight cycles with the divide-by-8 selection and the timer on
  sequence s_div8_run;
    (clk_sel == 2'h0 && timer_en) [*8];
  endsequence

  AST_START_BUSY: assert property (
    (start_req && !busy && i_wdata[`CB_NO_SYNC]) |=> s_calc_run)
    else $error("start did not launch calculation");
  AST_BUSY_READ: assert property (
    (i_rd && sel_b) |=> o_rdata[`CB_BUSY] == $past(busy))
    else $error("busy status wrong");
  AST_SYNC_WAIT: assert property (
    (state_r == st_wait_sync && !step_ev && calc_en) |=>
      state_r == st_wait_sync)
    else $error("calculation started without angle step");
  AST_IRQ_SRC: assert property (
    (calc_done && irq_sel_r) |=> o_irq_pulse ##1 !o_irq_pulse)
    else $error("calculation-end pulse missing");
  AST_COUNT_DIR: assert property (
    (step_ev && !(i_wr && sel_ang) && angle_r == 9'h005) |=>
      angle_r == ($past(down) ? 9'h004 : 9'h006))
    else $error("angle count direction wrong");
  AST_PRESCALE: assert property (
    (tick && clk_sel == 2'h0) ##1 s_div8_run |->
      tick && presc_r == 6'h07)
    else $error("prescaler divide by 8 wrong");
  AST_NO_XFER: assert property (
    (calc_done && !xfer_en) |=> !o_cmp_load && $stable(o_cmp_u))
    else $error("compare loaded while transfer off");
  AST_CALC_OFF: assert property (
    !calc_en |=> state_r == st_idle ##1 (!calc_en ? !busy : 1'b1))
    else $error("calculation active while disabled");
  AST_TIMER_STOP: assert property (
    (!timer_en && !(i_wr && sel_ang)) |=> $stable(angle_r))
    else $error("angle moved while timer off");
  AST_CAPTURE: assert property (
    cap_ev |=> capture_r == $past(angle_r))
    else $error("capture missed angle");
endmodule

// *** verif/pwm_position_partner.sv ***
/*
 Far-side model: PWM compare registers and the rotor position sensor.
 Assumes compare values are taken at the clock edge where load is high.
*/
`timescale 1ns/1ns
module pwm_position_partner (
  input  wire logic        i_clock,
  input  wire logic [11:0] i_cmp_u,
  input  wire logic [11:0] i_cmp_v,
  input  wire logic [11:0] i_cmp_w,
  input  wire logic        i_cmp_load,
  output logic             o_position
);
  logic [11:0] cmp_u_r;
  logic [11:0] cmp_v_r;
  logic [11:0] cmp_w_r;
  int          load_count;

  ////////////////////////////////////////////////////////////////////////////
  // Sensor line idles low, loads counted from zero
  initial begin
    o_position = 1'b0;
    load_count = 0;
  end

  // Compare registers take the duties on a load pulse
  always @(posedge i_clock) begin
    if (i_cmp_load === 1'b1) begin
      cmp_u_r    <= i_cmp_u;
      cmp_v_r    <= i_cmp_v;
      cmp_w_r    <= i_cmp_w;
      load_count <= load_count + 1;
    end
  end

  // Position edge lands away from the clock edge
  task automatic pulse_position();
    #37 o_position = 1'b1;
    #430 o_position = 1'b0;
  endtask
endmodule

// *** verif/electrical_angle_waveform_calc_test.sv ***
/*
 Self-checking bench for the angle timer and waveform unit.
 Assumes the register header and package are compiled first.
*/
`timescale 1ns/1ns
`include "angle_calc_regs.svh"
`define CHK(nm, e, g) check_val(nm, e, g)
module electrical_angle_waveform_calc_test;
  logic        i_clock;
  logic        i_reset_n;
  logic        i_clock_en;
  logic [15:0] i_addr;
  logic [15:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [15:0] o_rdata;
  logic        position;
  logic [11:0] o_cmp_u;
  logic [11:0] o_cmp_v;
  logic [11:0] o_cmp_w;
  logic        o_cmp_load;
  logic        o_irq;
  logic        o_irq_pulse;
  logic [15:0] rd_val;
  logic [15:0] v;
  int          mismatches;
  int          total_checks;
  int          cycles;
  int          seed;
  int          n;
  int          sum;
  int          voltage_amplitude;
  int          a;
  int          du;
  int          dv;
  int          dw;
  int          mn;
  int          sine_m [360];
  logic [15:0] rst_idx [9] = '{`IDX_CTRL_A, `IDX_CTRL_B, `IDX_PERIOD,
    `IDX_ANGLE, `IDX_AMP, `IDX_CAPTURE, `IDX_SINE, `IDX_IRQ_CLR, 16'h1fd0};
  logic [15:0] rw_idx [4] = '{`IDX_CTRL_A, `IDX_PERIOD, `IDX_ANGLE, `IDX_AMP};
  logic [15:0] rw_mask [4] = '{16'h00fc, 16'hffff, 16'h00ff, 16'h0fff};

  electrical_angle_waveform_calc #(.SINE_DEPTH(360))
    electrical_angle_waveform_calc_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clock_en(i_clock_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_position_detect(position), .o_cmp_u(o_cmp_u),
    .o_cmp_v(o_cmp_v), .o_cmp_w(o_cmp_w), .o_cmp_load(o_cmp_load),
    .o_irq(o_irq), .o_irq_pulse(o_irq_pulse));

  pwm_position_partner pwm_position_partner_inst (
    .i_clock(i_clock), .i_cmp_u(o_cmp_u), .i_cmp_v(o_cmp_v),
    .i_cmp_w(o_cmp_w), .i_cmp_load(o_cmp_load), .o_position(position));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles, waits and comparison
  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge i_clock);
    i_addr  <= 16'(idx << 2);
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx);
    @(posedge i_clock);
    i_addr <= 16'(idx << 2);
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1 rd_val = o_rdata;
  endtask

  // Counts edges until load (or interrupt pulse) is seen, up to a limit
  task automatic wait_event(input bit use_load, input int limit,
                            output int cnt);
    cnt = 0;
    do begin
      @(posedge i_clock);
      #1 cnt++;
    end while (((use_load ? o_cmp_load : o_irq_pulse) !== 1'b1)
               && cnt < limit);
  endtask

  task automatic check_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Duty model: amplitude-scaled sine, halved
  function automatic int duty(int amp_v, int ang);
    return (amp_v + amp_v * sine_m[ang] / 128) / 2;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 26;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    i_reset_n = 1'b0;
    i_clock_en = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    // Reset values, write-only and unmapped reads
    for (int k = 0; k < 9; k++) begin
      rd(rst_idx[k]);
      `CHK("reset", (k == 2) ? 16'h0010 : 16'h0000, rd_val);
    end
    // Random write and read back; period divider kept at 010 or more
    for (int k = 0; k < 4; k++) begin
      v = (16'($random(seed)) & rw_mask[k]) |
          ((k == 1) ? 16'h0010 : 16'h0000);
      wr(rw_idx[k], v);
      rd(rw_idx[k]);
      `CHK("readback", v, rd_val);
    end
    $display("test registers done");
    // Step period per clock select, direction per bit 7
    wr(`IDX_PERIOD, 16'h0010);
    wr(`IDX_CTRL_B, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_CTRL_A, 16'h0000);
      wr(`IDX_ANGLE, 16'h0005);
      wr(`IDX_CTRL_A, 16'(s << 4) | 16'h0001 | 16'((s & 1) << 7));
      wait_event(0, 9000, n);
      wait_event(0, 9000, n);
      `CHK("interval", 16 * (8 << s), n);
      rd(`IDX_ANGLE);
      `CHK("angle", (s & 1) ? 3 : 7, rd_val);
    end
    wr(`IDX_CTRL_A, 16'h0000);
    wr(`IDX_ANGLE, 16'h0000);
    wr(`IDX_CTRL_A, 16'h0081);
    wait_event(0, 300, n);
    rd(`IDX_ANGLE);
    `CHK("wrap", 359, rd_val);
    // Period correction: 15 of 16 steps one tick longer
    wr(`IDX_CTRL_A, 16'h0000);
    wr(`IDX_PERIOD, 16'hf010);
    wr(`IDX_CTRL_A, 16'h0001);
    wait_event(0, 300, n);
    sum = 0;
    for (int k = 0; k < 16; k++) begin
      wait_event(0, 300, n);
      sum += n;
    end
    `CHK("corrected", 271 * 8, sum);
    rd(`IDX_ANGLE);
    wr(`IDX_CTRL_A, 16'h0000);
    rd(`IDX_ANGLE);
    v = rd_val;
    repeat (300) @(posedge i_clock);
    rd(`IDX_ANGLE);
    `CHK("stopped", v, rd_val);
    $display("test timer done");
    // Sine table fill, then one calculation per mode and phase order
    for (int k = 0; k < 360; k++) begin
      v = 16'($random(seed)) & 16'h00ff;
      sine_m[k] = $signed(v[7:0]);
      wr(`IDX_SINE, v);
    end
    // Nonzero amplitude, a multiple of 128 so the scaling is exact
    voltage_amplitude = (($random(seed) & 15) + 16) * 128;
    wr(`IDX_AMP, 16'(voltage_amplitude));
    for (int m = 0; m < 4; m++) begin
      a = ($random(seed) & 255) + m * 26;
      wr(`IDX_ANGLE, 16'(a));
      wr(`IDX_CTRL_A, 16'h0006 | 16'((m & 1) << 3) | 16'((m & 2) << 5));
      wr(`IDX_CTRL_B, 16'h000b);
      // Load rises with the seventh edge after the start write edge
      wait_event(1, 12, n);
      `CHK("latency", 7, n);
      `CHK("done_pulse", 1, o_irq_pulse);
      du = duty(voltage_amplitude, a);
      dv = duty(voltage_amplitude, (a + ((m & 2) ? 240 : 120)) % 360);
      dw = duty(voltage_amplitude, (a + ((m & 2) ? 120 : 240)) % 360);
      mn = (du < dv) ? ((du < dw) ? du : dw) : ((dv < dw) ? dv : dw);
      if ((m & 1) == 0) begin
        du -= mn;
        dv -= mn;
        dw -= mn;
      end
      `CHK("cmp_u", du, o_cmp_u);
      `CHK("cmp_v", dv, o_cmp_v);
      `CHK("cmp_w", dw, o_cmp_w);
      rd(`IDX_CTRL_B);
      `CHK("idle", 16'h0003, rd_val);
      `CHK("part_w", dw, pwm_position_partner_inst.cmp_w_r);
    end
    $display("test calculation done");
    // Synchronised start waits; disable aborts; start ignored when off
    wr(`IDX_CTRL_A, 16'h0002);
    wr(`IDX_CTRL_B, 16'h0009);
    rd(`IDX_CTRL_B);
    `CHK("pending", 16'h0005, rd_val);
    wait_event(1, 20, n);
    `CHK("no_start", 20, n);
    wr(`IDX_CTRL_A, 16'h0000);
    rd(`IDX_CTRL_B);
    `CHK("abort", 16'h0001, rd_val);
    wr(`IDX_CTRL_B, 16'h000b);
    rd(`IDX_CTRL_B);
    `CHK("refused", 16'h0003, rd_val);
    n = pwm_position_partner_inst.load_count;
    wr(`IDX_CTRL_A, 16'h0002);
    wr(`IDX_CTRL_B, 16'h000b);
    wait_event(0, 12, sum);
    `CHK("end_pulse", 7, sum);
    `CHK("no_xfer", n, pwm_position_partner_inst.load_count);
    $display("test start control done");
    // Position capture and its interrupt: masked, raised, cleared
    wr(`IDX_CTRL_A, 16'h0000);
    wr(`IDX_ANGLE, 16'h0123);
    wr(`IDX_IRQ_EN, 16'h0000);
    pwm_position_partner_inst.pulse_position();
    repeat (6) @(posedge i_clock);
    rd(`IDX_CAPTURE);
    `CHK("capture", 16'h0123, rd_val);
    rd(`IDX_IRQ_STAT);
    `CHK("capt_flag", 1, rd_val[2]);
    `CHK("masked", 0, o_irq);
    wr(`IDX_IRQ_EN, 16'h0004);
    repeat (2) @(posedge i_clock);
    #1 `CHK("irq_on", 1, o_irq);
    wr(`IDX_IRQ_CLR, 16'h0004);
    repeat (2) @(posedge i_clock);
    #1 `CHK("irq_off", 0, o_irq);
    rd(`IDX_IRQ_STAT);
    `CHK("cleared", 0, rd_val[2]);
    $display("test capture done");
    print_verdict();
  end
endmodule
